// ===== hw/match_sequencer.sv
// Queued output match sequencer with timebase zero and APB register file
// Operation
// - Config bits 0,1,2 pick reference mode
// - Bit 4 continuous, else loop count passes
// - Process match count entries per pass
// - Stored reference used only in RAM mode
// - Entry is offset times two plus pin
// - Immediate mode samples timebase zero as reference
// - Trigger mode reads capture address, waits data
// - Write reference plus offset with control bits
// - Control upper bits eight plus one or two
// - Control 0x9 drives low, 0xA high
// - After write, read channel, stall until match
// - Returned match value becomes new reference
// - Loop counter decrements; continuous runs until disabled
// - Pointer advances, restarts each pass
// - Task disables itself when sequence completes
// - Channel read address holds sequencer route address
// - Blocked channel accepts nothing until match read
// - Enable requests copied only on host trigger
// - Software enables fields by writing 0b10
// - Timebase zero is a 24-bit counter
`timescale 1ns/100ps
`include "qom_params.svh"
module match_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cap_rd_req,
    input wire logic cap_valid,
    input wire qom_pkg::time_t cap_data,
    route_link_if.seq_mp link
);
    import qom_pkg::*;

    function automatic time_t entry_offset(input time_t entry);
        entry_offset = {1'b0, entry[`TB_W-1:1]};
    endfunction : entry_offset
    function automatic ctrl_t entry_ctrl(input time_t entry);
        entry_ctrl = `CTRL_UPPER + (entry[0] ? `CTRL_DRIVE_HIGH : `CTRL_DRIVE_LOW);
    endfunction : entry_ctrl

    logic [`TB_W-1:0] config_r;
    time_t loop_param_r, nmatch_param_r, ref_param_r, timebase_r, ref_r, loops_r, wr_data_r;
    time_t table_r [`TABLE_DEPTH];
    logic enable_r, done_r, wr_valid_r, rd_req_r, cap_rd_req_r, pready_r, pslverr_r;
    seq_state_t state_r;
    logic [`PTR_W-1:0] ptr_r, table_idx;
    logic [`CNT_W-1:0] left_r, pass_len;
    ctrl_t wr_ctrl_r;
    route_addr_t rd_addr_r;
    logic [31:0] prdata_r, rd_mux;
    logic apb_access, apb_write, mapped, table_hit, finish, stop_req;

    assign apb_access = psel && penable && !pready_r;
    assign apb_write = psel && penable && pready_r && pwrite && !pslverr_r;
    assign table_hit = (paddr >= `SEQ_TABLE_OFS) && (paddr <= `SEQ_TABLE_END)
        && (paddr[1:0] == 2'b00);
    assign table_idx = paddr[`PTR_W+1:2];
    // Entries beyond the table depth are clamped; the table holds only eight
    assign pass_len = (nmatch_param_r > `TABLE_DEPTH) ? `CNT_W'(`TABLE_DEPTH)
        : nmatch_param_r[`CNT_W-1:0];
    assign stop_req = apb_write && (paddr == `SEQ_CTRL_OFS) && !pwdata[`SEQ_CTRL_EN];

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        if (table_hit) begin
            rd_mux = {8'h00, table_r[table_idx]};
        end else begin
            unique case (paddr)
                `SEQ_CONFIG_OFS: rd_mux = {8'h00, config_r};
                `SEQ_LOOP_OFS: rd_mux = {8'h00, loop_param_r};
                `SEQ_NMATCH_OFS: rd_mux = {8'h00, nmatch_param_r};
                `SEQ_REF_OFS: rd_mux = {8'h00, ref_param_r};
                `SEQ_CTRL_OFS: rd_mux = {31'h0, enable_r};
                `SEQ_STATUS_OFS: rd_mux = {30'h0, state_r != SEQ_IDLE, done_r};
                `SEQ_TIMEBASE_OFS: rd_mux = {8'h00, timebase_r};
                default: mapped = 1'b0;
            endcase
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= apb_access;
            pslverr_r <= apb_access && !mapped;
            prdata_r <= (apb_access && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_r <= `TB_W'h0;
            loop_param_r <= `TB_W'h0;
            nmatch_param_r <= `TB_W'h0;
            ref_param_r <= `TB_W'h0;
            for (int i = 0; i < `TABLE_DEPTH; i++) begin
                table_r[i] <= `TB_W'h0;
            end
        end else if (apb_write && table_hit) begin
            table_r[table_idx] <= pwdata[`TB_W-1:0];
        end else if (apb_write) begin
            case (paddr)
                `SEQ_CONFIG_OFS: config_r <= pwdata[`TB_W-1:0];
                `SEQ_LOOP_OFS: loop_param_r <= pwdata[`TB_W-1:0];
                `SEQ_NMATCH_OFS: nmatch_param_r <= pwdata[`TB_W-1:0];
                `SEQ_REF_OFS: ref_param_r <= pwdata[`TB_W-1:0];
                default: ;
            endcase
        end
    end

    // Free running timebase; natural 24-bit wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_r <= `TB_W'h0;
        end else begin
            timebase_r <= timebase_r + `TB_W'h1;
        end
    end

    // Loop mode end: last entry matched and no passes left
    assign finish = (state_r == SEQ_PASS_END) && !config_r[`CFG_CONTINUOUS]
        && (loops_r <= `TB_W'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 1'b0;
        end else if (finish) begin
            enable_r <= 1'b0;
        end else if (apb_write && paddr == `SEQ_CTRL_OFS) begin
            enable_r <= pwdata[`SEQ_CTRL_EN];
        end
    end

    // Sticky completion flag; set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
        end else if (apb_write && paddr == `SEQ_STATUS_OFS && pwdata[`SEQ_STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SEQ_IDLE;
            ref_r <= `TB_W'h0;
            loops_r <= `TB_W'h0;
            ptr_r <= `PTR_W'h0;
            left_r <= `CNT_W'h0;
            wr_valid_r <= 1'b0;
            wr_data_r <= `TB_W'h0;
            wr_ctrl_r <= `CTRL_W'h0;
            rd_req_r <= 1'b0;
            rd_addr_r <= `ADDR_W'h0;
            cap_rd_req_r <= 1'b0;
        end else if (stop_req || (!enable_r && state_r != SEQ_IDLE)) begin
            // Disabling drops any pending routing request at once
            state_r <= SEQ_IDLE;
            wr_valid_r <= 1'b0;
            rd_req_r <= 1'b0;
            cap_rd_req_r <= 1'b0;
        end else begin
            unique case (state_r)
                SEQ_IDLE: begin
                    if (enable_r) begin
                        state_r <= SEQ_REF;
                        loops_r <= loop_param_r;
                    end
                end
                SEQ_REF: begin
                    ptr_r <= `PTR_W'h0;
                    left_r <= pass_len;
                    state_r <= SEQ_FETCH;
                    if (config_r[`CFG_REF_RAM]) begin
                        ref_r <= ref_param_r;
                    end else if (config_r[`CFG_REF_IMMED]) begin
                        ref_r <= timebase_r;
                    end else if (config_r[`CFG_REF_TRIG]) begin
                        cap_rd_req_r <= 1'b1;
                        state_r <= SEQ_TRIG_WAIT;
                    end else begin
                        state_r <= SEQ_PASS_END;
                        loops_r <= `TB_W'h0;
                    end
                end
                SEQ_TRIG_WAIT: begin
                    if (cap_valid) begin
                        ref_r <= cap_data;
                        cap_rd_req_r <= 1'b0;
                        state_r <= SEQ_FETCH;
                    end
                end
                SEQ_FETCH: begin
                    if (left_r == `CNT_W'h0) begin
                        state_r <= SEQ_PASS_END;
                    end else begin
                        wr_data_r <= ref_r + entry_offset(table_r[ptr_r]);
                        wr_ctrl_r <= entry_ctrl(table_r[ptr_r]);
                        wr_valid_r <= 1'b1;
                        state_r <= SEQ_WRITE;
                    end
                end
                SEQ_WRITE: begin
                    if (link.wr_ready) begin
                        wr_valid_r <= 1'b0;
                        rd_req_r <= 1'b1;
                        rd_addr_r <= `SEQ_ROUTE_ADDR;
                        state_r <= SEQ_WAIT_MATCH;
                    end
                end
                SEQ_WAIT_MATCH: begin
                    if (link.rd_valid) begin
                        rd_req_r <= 1'b0;
                        ref_r <= link.rd_data;
                        ptr_r <= ptr_r + `PTR_W'h1;
                        left_r <= left_r - `CNT_W'h1;
                        state_r <= SEQ_FETCH;
                    end
                end
                SEQ_PASS_END: begin
                    // Next pass keeps the last match as its reference
                    if (config_r[`CFG_CONTINUOUS]) begin
                        ptr_r <= `PTR_W'h0;
                        left_r <= pass_len;
                        state_r <= SEQ_FETCH;
                    end else if (loops_r > `TB_W'h1) begin
                        loops_r <= loops_r - `TB_W'h1;
                        ptr_r <= `PTR_W'h0;
                        left_r <= pass_len;
                        state_r <= SEQ_FETCH;
                    end else begin
                        loops_r <= `TB_W'h0;
                        state_r <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cap_rd_req = cap_rd_req_r;
    assign link.wr_valid = wr_valid_r;
    assign link.wr_addr = `SEQ_ROUTE_ADDR;
    assign link.wr_data = wr_data_r;
    assign link.wr_ctrl = wr_ctrl_r;
    assign link.rd_req = rd_req_r;
    assign link.rd_addr = rd_addr_r;
    assign link.timebase = timebase_r;
endmodule : match_sequencer

// ===== hw/output_compare_channel.sv
// Output compare channel end: blocking compare, pin drive, global update
`timescale 1ns/100ps
`include "qom_params.svh"
module output_compare_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pin_out,
    output logic pin_oe,
    route_link_if.chan_mp link
);
    import qom_pkg::*;

    function automatic logic [1:0] field_update(input logic [1:0] cur, input logic [1:0] req);
        field_update = (req == `FIELD_ENABLE) ? 2'b10 : (req == `FIELD_DISABLE) ? 2'b00 : cur;
    endfunction : field_update

    route_addr_t rdaddr_r;
    logic [1:0] outen_req_r;
    logic [1:0] endis_req_r;
    logic [1:0] outen_state_r;
    logic [1:0] endis_state_r;
    time_t cm0_r;
    ctrl_t ctrl_r;
    logic armed_r;
    logic matched_r;
    time_t shadow_r;
    logic pin_r;
    logic rd_valid_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic apb_access;
    logic apb_write;
    logic mapped;
    logic [31:0] rd_mux;
    logic enabled;
    logic blocked;
    logic take;
    logic hit;

    assign apb_access = psel && penable && !pready_r;
    assign apb_write = psel && penable && pready_r && pwrite && !pslverr_r;
    assign enabled = (endis_state_r == 2'b10);
    assign blocked = armed_r || matched_r;
    assign take = enabled && !blocked && link.wr_valid && (link.wr_addr == rdaddr_r);
    assign hit = armed_r && (link.timebase == cm0_r) && (ctrl_r[4:2] == `CTRL_UPPER >> 2);

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        unique case (paddr)
            `CH_RDADDR_OFS: rd_mux = {23'h0, rdaddr_r};
            `CH_OUTEN_REQ_OFS: rd_mux = {30'h0, outen_req_r};
            `CH_ENDIS_REQ_OFS: rd_mux = {30'h0, endis_req_r};
            `CH_GLB_CTRL_OFS: rd_mux = 32'h0;
            `CH_OUTEN_STATE_OFS: rd_mux = {30'h0, outen_state_r};
            `CH_ENDIS_STATE_OFS: rd_mux = {30'h0, endis_state_r};
            `CH_STATUS_OFS: rd_mux = {29'h0, pin_r, matched_r, armed_r};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= apb_access;
            pslverr_r <= apb_access && !mapped;
            prdata_r <= (apb_access && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdaddr_r <= `RDADDR_RESET;
            outen_req_r <= 2'b00;
            endis_req_r <= 2'b00;
        end else if (apb_write) begin
            if (paddr == `CH_RDADDR_OFS) begin
                rdaddr_r <= pwdata[`ADDR_W-1:0];
            end
            if (paddr == `CH_OUTEN_REQ_OFS) begin
                outen_req_r <= pwdata[1:0];
            end
            if (paddr == `CH_ENDIS_REQ_OFS) begin
                endis_req_r <= pwdata[1:0];
            end
        end
    end

    // Requests reach the state only with the host trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outen_state_r <= 2'b00;
            endis_state_r <= 2'b00;
        end else if (apb_write && paddr == `CH_GLB_CTRL_OFS && pwdata[`GLB_HOST_TRIG]) begin
            outen_state_r <= field_update(outen_state_r, outen_req_r);
            endis_state_r <= field_update(endis_state_r, endis_req_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cm0_r <= `TB_W'h0;
            ctrl_r <= `CTRL_W'h0;
            armed_r <= 1'b0;
            matched_r <= 1'b0;
            shadow_r <= `TB_W'h0;
            pin_r <= 1'b0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= 1'b0;
            if (take) begin
                cm0_r <= link.wr_data;
                ctrl_r <= link.wr_ctrl;
                armed_r <= 1'b1;
            end else if (hit) begin
                armed_r <= 1'b0;
                matched_r <= 1'b1;
                shadow_r <= link.timebase;
                if (ctrl_r[1:0] == `CTRL_DRIVE_HIGH) begin
                    pin_r <= 1'b1;
                end else if (ctrl_r[1:0] == `CTRL_DRIVE_LOW) begin
                    pin_r <= 1'b0;
                end
            end else if (matched_r && !rd_valid_r && link.rd_req && link.rd_addr == rdaddr_r) begin
                // Handing out the shadow value releases the block
                rd_valid_r <= 1'b1;
                matched_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_r;
    // Only 2'b10 or 2'b00 is ever stored, so the upper bit is the enable
    assign pin_oe = outen_state_r[1];
    assign link.wr_ready = enabled && !blocked && (link.wr_addr == rdaddr_r);
    assign link.rd_valid = rd_valid_r;
    assign link.rd_data = shadow_r;
endmodule : output_compare_channel

// ===== hw/qom_params.svh
// Offsets, field positions, reset values and encodings for the match sequencer pair
`ifndef QOM_PARAMS_SVH
`define QOM_PARAMS_SVH

`define TB_W 24
`define CTRL_W 5
`define ADDR_W 9
`define TABLE_DEPTH 8
`define PTR_W 3
`define CNT_W 4

// Routing addresses
`define SEQ_ROUTE_ADDR 9'h077
`define CAP_ROUTE_ADDR 9'h001

// Task configuration word bits
`define CFG_REF_RAM 0
`define CFG_REF_IMMED 1
`define CFG_REF_TRIG 2
`define CFG_CONTINUOUS 4

// Control bits sent with each match time
`define CTRL_UPPER 5'h08
`define CTRL_DRIVE_LOW 5'h01
`define CTRL_DRIVE_HIGH 5'h02

// Sequencer register offsets
`define SEQ_CONFIG_OFS 8'h00
`define SEQ_LOOP_OFS 8'h04
`define SEQ_NMATCH_OFS 8'h08
`define SEQ_REF_OFS 8'h0c
`define SEQ_CTRL_OFS 8'h10
`define SEQ_STATUS_OFS 8'h14
`define SEQ_TIMEBASE_OFS 8'h18
`define SEQ_TABLE_OFS 8'h20
`define SEQ_TABLE_END 8'h3c

// Sequencer control and status fields
`define SEQ_CTRL_EN 0
`define SEQ_STAT_DONE 0
`define SEQ_STAT_BUSY 1

// Output channel register offsets
`define CH_RDADDR_OFS 8'h00
`define CH_OUTEN_REQ_OFS 8'h04
`define CH_ENDIS_REQ_OFS 8'h08
`define CH_GLB_CTRL_OFS 8'h0c
`define CH_OUTEN_STATE_OFS 8'h10
`define CH_ENDIS_STATE_OFS 8'h14
`define CH_STATUS_OFS 8'h18

`define GLB_HOST_TRIG 0
`define FIELD_ENABLE 2'b10
`define FIELD_DISABLE 2'b01

`define RDADDR_RESET 9'h000
`endif

// ===== hw/qom_pkg.sv
// Types shared by the match sequencer and the output compare channel
package qom_pkg;
    typedef logic [23:0] time_t;
    typedef logic [4:0] ctrl_t;
    typedef logic [8:0] route_addr_t;
    typedef enum {
        SEQ_IDLE, SEQ_REF, SEQ_TRIG_WAIT, SEQ_FETCH, SEQ_WRITE, SEQ_WAIT_MATCH, SEQ_PASS_END
    } seq_state_t;
endpackage : qom_pkg

// ===== hw/route_link_if.sv
// Routing link between the match sequencer and the output compare channel
`timescale 1ns/100ps
interface route_link_if;
    import qom_pkg::*;
    logic wr_valid;
    route_addr_t wr_addr;
    time_t wr_data;
    ctrl_t wr_ctrl;
    logic wr_ready;
    logic rd_req;
    route_addr_t rd_addr;
    logic rd_valid;
    time_t rd_data;
    time_t timebase;

    modport seq_mp (
        output wr_valid,
        output wr_addr,
        output wr_data,
        output wr_ctrl,
        input wr_ready,
        output rd_req,
        output rd_addr,
        input rd_valid,
        input rd_data,
        output timebase
    );

    modport chan_mp (
        input wr_valid,
        input wr_addr,
        input wr_data,
        input wr_ctrl,
        output wr_ready,
        input rd_req,
        input rd_addr,
        output rd_valid,
        output rd_data,
        input timebase
    );
endinterface : route_link_if

// ===== verification/qom_link_properties.sv
// Routing link properties for the match sequencer pair
`timescale 1ns/100ps
module qom_link_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_valid,
    input wire qom_pkg::route_addr_t wr_addr,
    input wire qom_pkg::time_t wr_data,
    input wire qom_pkg::ctrl_t wr_ctrl,
    input wire logic wr_ready,
    input wire logic rd_req,
    input wire qom_pkg::route_addr_t rd_addr,
    input wire logic rd_valid,
    input wire qom_pkg::time_t rd_data,
    input wire qom_pkg::time_t timebase
);
    import qom_pkg::*;
    time_t last_wr_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Scheduled time; the channel must hand back exactly this at its match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            last_wr_r <= '0;
        else if (wr_valid && wr_ready)
            last_wr_r <= wr_data;
    end
    a_tb_counts: assert property ($past(presetn) |-> timebase == $past(timebase) + 24'h1)
        else $error("timebase did not step by one");
    a_ctrl_code: assert property (wr_valid |-> wr_ctrl inside {5'h09, 5'h0a})
        else $error("bad control code");
    a_route_addr: assert property ((!wr_valid || wr_addr == 9'h077) && (!rd_req || rd_addr == 9'h077))
        else $error("wrong routing address");
    a_wr_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) && $stable(wr_ctrl))
        else $error("write dropped or changed");
    a_read_follows: assert property (wr_valid && wr_ready |=> rd_req && !wr_valid)
        else $error("no read after write");
    a_chan_blocked: assert property (rd_req && !rd_valid |-> !wr_ready)
        else $error("channel open while armed");
    a_match_value: assert property (rd_valid |-> rd_data == last_wr_r)
        else $error("returned value is not the match time");
    a_match_prompt: assert property (rd_req && timebase == last_wr_r |-> ##[1:3] rd_valid)
        else $error("match not returned");
    a_read_release: assert property (rd_valid |=> !rd_req)
        else $error("read held after answer");
    c_drive_low: cover property (wr_valid && wr_ready && wr_ctrl == 5'h09);
    c_drive_high: cover property (wr_valid && wr_ready && wr_ctrl == 5'h0a);
    c_match_back: cover property (rd_valid ##[1:4] wr_valid);
endmodule : qom_link_properties

// ===== verification/queued_output_match_sequencer_tb_top.sv
// Bench joining the match sequencer to the output compare channel
`timescale 1ns/100ps
module queued_output_match_sequencer_tb_top;
    logic pclk = 0, presetn = 0, psel_s = 0, psel_c = 0, penable = 0, pwrite = 0;
    logic cap_valid = 0, pready_s, pready_c, pslverr_s, pslverr_c, cap_rd_req, pin_out, pin_oe;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_s, prdata_c;
    qom_pkg::time_t cap_data = '0;
    integer seed = 32'h1bdc5e28;
    int num_errors = 0, n_checks = 0;
    logic [28:0] exw[$];
    logic [32:0] exr[$];
    logic [23:0] off[8];
    logic pin[8];
    always #5 pclk = ~pclk;
    route_link_if route_link_if_i ();
    match_sequencer match_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel_s),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s),
        .pready(pready_s), .pslverr(pslverr_s), .cap_rd_req(cap_rd_req), .cap_valid(cap_valid),
        .cap_data(cap_data), .link(route_link_if_i.seq_mp));
    output_compare_channel output_compare_channel_i (.pclk(pclk), .presetn(presetn),
        .psel(psel_c), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_c), .pready(pready_c), .pslverr(pslverr_c), .pin_out(pin_out),
        .pin_oe(pin_oe), .link(route_link_if_i.chan_mp));
    qom_link_properties qom_link_properties_i (.pclk(pclk), .presetn(presetn),
        .wr_valid(route_link_if_i.wr_valid), .wr_addr(route_link_if_i.wr_addr),
        .wr_data(route_link_if_i.wr_data), .wr_ctrl(route_link_if_i.wr_ctrl),
        .wr_ready(route_link_if_i.wr_ready), .rd_req(route_link_if_i.rd_req),
        .rd_addr(route_link_if_i.rd_addr), .rd_valid(route_link_if_i.rd_valid),
        .rd_data(route_link_if_i.rd_data), .timebase(route_link_if_i.timebase));
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // c selects the channel end; the request is held until pready is seen
    task automatic apb(input bit c, input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel_s <= !c;
        psel_c <= c;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!(c ? pready_c : pready_s));
        psel_s <= 1'b0;
        psel_c <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input bit c, input logic [7:0] a, input logic [32:0] e);
        exr.push_back(e);
        apb(c, 1'b0, a, 32'h0);
    endtask : rd
    // Writes are noted once the reference of the mode is known
    task automatic run(input logic [31:0] cfg, input int lc, input int n, input int np);
        logic [23:0] r;
        apb(0, 1, 8'h00, cfg);
        apb(0, 1, 8'h04, lc);
        apb(0, 1, 8'h08, n);
        for (int i = 0; i < n; i++) begin
            off[i] = 24'h10 + 24'($random(seed) & 32'h3f);
            pin[i] = 1'($random(seed));
            apb(0, 1, 8'h20 + 8'(4 * i), {7'h0, off[i], pin[i]});
        end
        r = route_link_if_i.timebase + 24'h80;
        apb(0, 1, 8'h0c, {8'h0, cfg[0] ? r : ~r});
        apb(0, 1, 8'h10, 32'h1);
        // Enable lands at this edge; the timebase is taken as reference two edges on
        if (cfg[1])
            r = route_link_if_i.timebase + 24'h2;
        for (int p = 0; p < np; p++)
            for (int i = 0; i < n; i++) begin
                r = r + off[i];
                exw.push_back({pin[i] ? 5'h0a : 5'h09, r});
            end
        if (cfg[2]) begin
            wait (cap_rd_req);
            @(posedge pclk);
            cap_valid <= 1'b1;
            cap_data <= r - off[0] - off[1];
            @(posedge pclk);
            cap_valid <= 1'b0;
            cap_data <= ~cap_data;
        end
        wait (exw.size() == 0);
    endtask : run
    task automatic fin();
        @(posedge pclk iff route_link_if_i.rd_valid);
        repeat (4) @(posedge pclk);
        rd(0, 8'h14, 33'h1);
        rd(0, 8'h10, 33'h0);
        apb(0, 1, 8'h14, 32'h1);
        rd(0, 8'h14, 33'h0);
    endtask : fin
    always @(posedge pclk) begin : mon
        logic [28:0] e;
        logic pin_e;
        if (route_link_if_i.wr_valid && route_link_if_i.wr_ready) begin
            e = exw.pop_front();
            pin_e = e[25];
            chk({4'h0, route_link_if_i.wr_ctrl, route_link_if_i.wr_data},
                {4'h0, e});
        end
        // The pin changes at the match, one edge before the shadow value comes back
        if (route_link_if_i.rd_valid)
            chk({32'h0, pin_out}, {32'h0, pin_e});
        if ((psel_s || psel_c) && penable && !pwrite && (psel_c ? pready_c : pready_s))
            chk(psel_c ? {pslverr_c, prdata_c} : {pslverr_s, prdata_s}, exr.pop_front());
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, 1, 8'h00, 32'h77);
        apb(1, 1, 8'h04, 32'h2);
        apb(1, 1, 8'h08, 32'h2);
        rd(1, 8'h14, 33'h0);
        apb(1, 1, 8'h0c, 32'h1);
        rd(1, 8'h10, 33'h2);
        rd(1, 8'h14, 33'h2);
        chk({32'h0, pin_oe}, 33'h1);
        rd(0, 8'h40, {1'b1, 32'h0});
        run(32'h1, 2, 3, 2);
        fin();
        run(32'h2, 1, 2, 1);
        fin();
        run(32'h4, 0, 2, 1);
        fin();
        run(32'h11, 5, 2, 3);
        apb(0, 1, 8'h10, 32'h0);
        rd(0, 8'h14, 33'h0);
        // Quiet span longer than any offset: a stray write pops an empty queue
        repeat (200) @(posedge pclk);
        stop_test();
    end
    initial begin
        // Sixteen matches of under two hundred and ten cycles plus register traffic
        #300000;
        num_errors++;
        stop_test();
    end
endmodule : queued_output_match_sequencer_tb_top
